// ### rtcm_pkg.sv
// constants and carriers for the alarm, interrupt and supply monitor block
package rtcm_pkg;
    localparam logic [3:0] ADDR_INT_EN = 4'he;
    localparam logic [3:0] ADDR_STATUS = 4'hf;
    localparam int BIT_WEEKDAY_ALARM_ENABLE = 7;
    localparam int BIT_DAILY_ALARM_ENABLE = 6;
    localparam int BIT_CT_HI = 2;
    localparam int BIT_SUPPLY_THRESHOLD_SELECT = 7;
    localparam int BIT_LOWSUP = 6;
    localparam int BIT_PON = 4;
    localparam int BIT_PERIODIC_FLAG = 2;
    localparam int BIT_WEEKDAY_ALARM_FLAG = 1;
    localparam int BIT_DAILY_ALARM_FLAG = 0;
    localparam logic [7:0] INT_EN_RESET = 8'h00;
    localparam logic [2:0] CT_OFF = 3'h0;
    localparam logic [2:0] CT_LOW = 3'h1;
    localparam logic [2:0] CT_2HZ = 3'h2;
    localparam logic [2:0] CT_1HZ = 3'h3;
    localparam logic [2:0] CT_SEC = 3'h4;
    localparam logic [2:0] CT_MIN = 3'h5;
    localparam logic [2:0] CT_HOUR = 3'h6;
    localparam logic [2:0] CT_MONTH = 3'h7;
    localparam int CLK_HZ = 20_000_000;
    localparam real SAMPLE_MS = 7.8;
    localparam int SAMPLE_CYCLES = int'(SAMPLE_MS * CLK_HZ / 1000.0);
    localparam int SAMPLE_W = 18;
    localparam int RELEASE_DELAY_MS = 1000;
    localparam int RELEASE_CYCLES_DEF = RELEASE_DELAY_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [2:0] weekday;
    } rtcm_time_t;

    typedef struct packed {
        logic sec_tick;
        logic min_tick;
        logic hour_tick;
        logic month_tick;
        logic half_sec_level;
    } rtcm_ticks_t;

    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtcm_reg_req_t;
endpackage

// ### rtcm_monitor.sv
// alarm, periodic interrupt, supply monitor and host reset logic
// Functional notes
// - internal supply sampled 7.8 ms window once per second only
// - threshold select 0 chooses high level, 1 chooses low level
// - sampling stops while low-supply flag is set
// - low-supply result kept at status bit 6, not on a pin
// - threshold select is writable status bit 7
// - one detection level both directions, no hysteresis
// - main supply low drives host reset low, selects battery
// - reset release after delay once supply is good and oscillator is running
// - supply select follows main supply detector
// - alarms match weekday/hour/minute or hour/minute, set flag, drive irq
// - periodic select in enable register bits 2..0; zero disables
// - flags at status bits 1, 0 and 2
// - alarm enables at enable register bits 7 and 6
// - alarm works only while its enable is 1
// - write 1 to alarm flag ignored, write 0 clears it
// - clearing flag keeps enable; alarm fires on next match
// - interrupt output low when any source asserts
// - all enables zero at power-on keeps interrupt high
// - enabling during a match does not fire until next match
// - low-supply flag cleared only by write 0; zero at power-up
// - power-up flag clears enables, select, threshold and flags
// - periodic modes off, low, 2 Hz, 1 Hz, level second..month
// - level mode holds output low until periodic flag cleared
`timescale 1ns/1ps
`default_nettype none
module rtcm_monitor #(
    parameter int RELEASE_CYCLES = rtcm_pkg::RELEASE_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire rtcm_pkg::rtcm_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire rtcm_pkg::rtcm_time_t cur_time,
    input wire rtcm_pkg::rtcm_time_t alarm_w_time,
    input wire rtcm_pkg::rtcm_time_t alarm_d_time,
    input wire rtcm_pkg::rtcm_ticks_t ticks,
    input wire logic power_up_flag,
    input wire logic osc_running,
    input wire logic main_supply_above,
    input wire logic supply_below_high,
    input wire logic supply_below_low,
    output logic supply_sample_en,
    output logic main_supply_switch,
    output logic battery_supply_switch,
    output logic host_reset_out_n,
    output logic interrupt_out_n,
    output logic interrupt_out_oe
);
    import rtcm_pkg::*;

    // refuse at elaboration what the counters cannot hold
    if (RELEASE_CYCLES < 1 || SAMPLE_CYCLES >= (1 << SAMPLE_W)) begin : g_bad
        $error("rtcm_monitor: unsupported timing parameters");
    end

    function automatic logic wr_to(input rtcm_reg_req_t r,
                                   input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    logic weekday_alarm_enable;
    logic daily_alarm_enable;
    logic [2:0] periodic_select;
    logic supply_threshold_select;
    logic low_supply_flag;
    logic weekday_alarm_flag;
    logic daily_alarm_flag;
    logic periodic_flag;
    logic wr_en;
    logic wr_st;

    assign wr_en = wr_to(reg_req, ADDR_INT_EN);
    assign wr_st = wr_to(reg_req, ADDR_STATUS);

    // enable register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            weekday_alarm_enable <= 1'b0;
            daily_alarm_enable <= 1'b0;
            periodic_select <= CT_OFF;
        end else if (power_up_flag) begin
            weekday_alarm_enable <= 1'b0;
            daily_alarm_enable <= 1'b0;
            periodic_select <= CT_OFF;
        end else if (wr_en) begin
            weekday_alarm_enable <= reg_req.wdata[BIT_WEEKDAY_ALARM_ENABLE];
            daily_alarm_enable <= reg_req.wdata[BIT_DAILY_ALARM_ENABLE];
            periodic_select <= reg_req.wdata[BIT_CT_HI:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supply_threshold_select <= 1'b0;
        end else if (power_up_flag) begin
            supply_threshold_select <= 1'b0;
        end else if (wr_st) begin
            supply_threshold_select <= reg_req.wdata[BIT_SUPPLY_THRESHOLD_SELECT];
        end
    end

    // alarm matching, sampled only on the minute tick so an enable or
    // flag clear inside a matching minute cannot re-fire
    logic w_match;
    logic d_match;
    assign w_match = weekday_alarm_enable && ticks.min_tick &&
                     cur_time == alarm_w_time;
    assign d_match = daily_alarm_enable && ticks.min_tick &&
                     cur_time.hour == alarm_d_time.hour &&
                     cur_time.minute == alarm_d_time.minute;

    // flags: hardware set beats software clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            weekday_alarm_flag <= 1'b0;
            daily_alarm_flag <= 1'b0;
        end else if (power_up_flag) begin
            weekday_alarm_flag <= 1'b0;
            daily_alarm_flag <= 1'b0;
        end else begin
            if (w_match) begin
                weekday_alarm_flag <= 1'b1;
            end else if (wr_st && !reg_req.wdata[BIT_WEEKDAY_ALARM_FLAG]) begin
                weekday_alarm_flag <= 1'b0;
            end
            if (d_match) begin
                daily_alarm_flag <= 1'b1;
            end else if (wr_st && !reg_req.wdata[BIT_DAILY_ALARM_FLAG]) begin
                daily_alarm_flag <= 1'b0;
            end
        end
    end

    // periodic event selection
    logic level_event;
    always_comb begin
        unique case (periodic_select)
            CT_SEC: level_event = ticks.sec_tick;
            CT_MIN: level_event = ticks.min_tick;
            CT_HOUR: level_event = ticks.hour_tick;
            CT_MONTH: level_event = ticks.month_tick;
            default: level_event = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            periodic_flag <= 1'b0;
        end else if (power_up_flag) begin
            periodic_flag <= 1'b0;
        end else if (level_event) begin
            periodic_flag <= 1'b1;
        end else if (wr_st && !reg_req.wdata[BIT_PERIODIC_FLAG]) begin
            periodic_flag <= 1'b0;
        end
    end

    logic periodic_req;
    always_comb begin
        unique case (periodic_select)
            CT_OFF: periodic_req = 1'b0;
            CT_LOW: periodic_req = 1'b1;
            CT_2HZ: periodic_req = ticks.half_sec_level;
            CT_1HZ: periodic_req = !ticks.sec_tick &&
                                   ticks.half_sec_level;
            default: periodic_req = periodic_flag;
        endcase
    end

    // pulse-mode 1 Hz approximated from the half-second level; a
    // second-aligned divider is left to the time counter block
    logic any_req;
    assign any_req = weekday_alarm_flag || daily_alarm_flag ||
                     periodic_req;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
            interrupt_out_oe <= 1'b0;
        end else begin
            interrupt_out_n <= !any_req;
            interrupt_out_oe <= any_req;
        end
    end

    // supply sampling window, once per second
    logic [SAMPLE_W-1:0] sample_cnt;
    logic sampling;
    logic below_now;
    assign sampling = sample_cnt != '0;
    assign below_now = supply_threshold_select ? supply_below_low
                                               : supply_below_high;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sample_cnt <= '0;
        end else if (ticks.sec_tick && !low_supply_flag && !sampling) begin
            sample_cnt <= SAMPLE_W'(SAMPLE_CYCLES);
        end else if (sampling) begin
            sample_cnt <= sample_cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supply_sample_en <= 1'b0;
        end else begin
            supply_sample_en <= sampling && !low_supply_flag;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_supply_flag <= 1'b0;
        end else if (power_up_flag) begin
            low_supply_flag <= 1'b0;
        end else if (supply_sample_en && below_now) begin
            low_supply_flag <= 1'b1;
        end else if (wr_st && !reg_req.wdata[BIT_LOWSUP]) begin
            low_supply_flag <= 1'b0;
        end
    end

    // main supply monitor and host reset release
    logic [31:0] rel_cnt;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rel_cnt <= '0;
            host_reset_out_n <= 1'b0;
        end else if (!main_supply_above || !osc_running) begin
            rel_cnt <= '0;
            host_reset_out_n <= 1'b0;
        end else if (rel_cnt >= 32'(RELEASE_CYCLES - 1)) begin
            host_reset_out_n <= 1'b1;
        end else begin
            rel_cnt <= rel_cnt + 32'd1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            main_supply_switch <= 1'b0;
            battery_supply_switch <= 1'b1;
        end else begin
            main_supply_switch <= main_supply_above;
            battery_supply_switch <= !main_supply_above;
        end
    end

    // register read data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.addr == ADDR_INT_EN) begin
            reg_rdata <= {weekday_alarm_enable, daily_alarm_enable,
                          3'h0, periodic_select};
        end else if (reg_req.addr == ADDR_STATUS) begin
            reg_rdata <= {supply_threshold_select, low_supply_flag, 1'b0,
                          power_up_flag, 1'b0, periodic_flag,
                          weekday_alarm_flag, daily_alarm_flag};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    AST_IRQ_ALARM: assert property (@(posedge sys_clk)
        disable iff (rst) d_match |=> ##1 !interrupt_out_n)
        else $error("alarm match did not pull interrupt low");
    AST_NO_MATCH_DISABLED: assert property (@(posedge sys_clk)
        disable iff (rst) !daily_alarm_enable && !daily_alarm_flag
        |=> !daily_alarm_flag)
        else $error("disabled alarm set its flag");
    AST_FLAG_CLEAR: assert property (@(posedge sys_clk)
        disable iff (rst)
        wr_st && !reg_req.wdata[BIT_WEEKDAY_ALARM_FLAG] && !w_match && !power_up_flag
        |=> !weekday_alarm_flag)
        else $error("weekday flag not cleared by write 0");
    AST_ENABLE_KEPT: assert property (@(posedge sys_clk)
        disable iff (rst)
        wr_st && !power_up_flag |=> $stable(daily_alarm_enable))
        else $error("status write changed an enable");
    AST_IRQ_IDLE: assert property (@(posedge sys_clk)
        disable iff (rst)
        !weekday_alarm_flag && !daily_alarm_flag &&
        periodic_select == CT_OFF |=> interrupt_out_n)
        else $error("interrupt low with all sources off");
    AST_SAMPLE_HALT: assert property (@(posedge sys_clk)
        disable iff (rst) low_supply_flag |=> !supply_sample_en)
        else $error("sampling continued with low-supply flag set");
    AST_RESET_LOW: assert property (@(posedge sys_clk)
        disable iff (rst)
        !main_supply_above |=> !host_reset_out_n && battery_supply_switch)
        else $error("main supply low not followed by reset");
    AST_PON_CLEAR: assert property (@(posedge sys_clk)
        disable iff (rst)
        power_up_flag |=> periodic_select == CT_OFF && !low_supply_flag)
        else $error("power-up flag did not clear controls");
    AST_IRQ_ANY: assert property (@(posedge sys_clk)
        disable iff (rst) weekday_alarm_flag || daily_alarm_flag
        |=> !interrupt_out_n && interrupt_out_oe)
        else $error("alarm flag set but interrupt not driven");
    AST_SUPPLY_SWITCH: assert property (@(posedge sys_clk)
        disable iff (rst)
        main_supply_above |=> main_supply_switch && !battery_supply_switch)
        else $error("main supply good but battery still selected");
    AST_LEVEL_HOLD: assert property (@(posedge sys_clk)
        disable iff (rst) periodic_flag && periodic_select[2]
        |=> !interrupt_out_n)
        else $error("level-mode periodic flag not driving interrupt");
endmodule
`default_nettype wire

// ### rtcm_host_model.sv
// host-side register access model for the monitor block
`timescale 1ns/1ps
`default_nettype none
module rtcm_host_model (
    input wire logic sys_clk,
    output var rtcm_pkg::rtcm_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import rtcm_pkg::*;
    initial reg_req = '0;
    // strobe lasts one cycle; requests move only on falling edges
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(negedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    // read data is registered, so it is taken one cycle later
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### rtcm_monitor_bench.sv
// self-checking bench for the alarm, interrupt and supply monitor
`timescale 1ns/1ps
`default_nettype none
module rtcm_monitor_bench;
    import rtcm_pkg::*;
    localparam int REL = 16;
    logic sys_clk, rst, power_up_flag, osc_running, main_supply_above;
    logic supply_below_high, supply_below_low, supply_sample_en;
    logic main_supply_switch, battery_supply_switch, host_reset_out_n;
    logic interrupt_out_n, interrupt_out_oe;
    logic [7:0] reg_rdata, rv;
    rtcm_time_t cur_time, alarm_w_time, alarm_d_time;
    rtcm_ticks_t ticks;
    rtcm_reg_req_t reg_req;
    int miscompares = 0;
    int n_checks = 0;
    int n;
    rtcm_monitor #(.RELEASE_CYCLES(REL)) dut_u (.sys_clk(sys_clk),
        .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .cur_time(cur_time), .alarm_w_time(alarm_w_time),
        .alarm_d_time(alarm_d_time), .ticks(ticks),
        .power_up_flag(power_up_flag), .osc_running(osc_running),
        .main_supply_above(main_supply_above),
        .supply_below_high(supply_below_high),
        .supply_below_low(supply_below_low),
        .supply_sample_en(supply_sample_en),
        .main_supply_switch(main_supply_switch),
        .battery_supply_switch(battery_supply_switch),
        .host_reset_out_n(host_reset_out_n),
        .interrupt_out_n(interrupt_out_n),
        .interrupt_out_oe(interrupt_out_oe));
    rtcm_host_model host_u (.sys_clk(sys_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task automatic pulse(input rtcm_ticks_t m);
        ticks = m;
        cyc(1);
        ticks = '0;
        cyc(3);
    endtask
    task automatic irq(input logic exp);
        chk(8'(interrupt_out_n), 8'(exp));
        chk(8'(interrupt_out_oe), 8'(!exp));
    endtask
    task automatic st(input logic [7:0] exp);
        host_u.rd(ADDR_STATUS, rv);
        chk(rv, exp);
    endtask
    task automatic rel_wait();
        n = 0;
        while (host_reset_out_n !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 64) begin
                miscompares++;
                stop_test();
            end
        end
        chk(8'(n >= REL && n <= REL + 3), 8'h01);
    endtask
    task automatic s_reset();
        host_u.rd(ADDR_INT_EN, rv);
        chk(rv, INT_EN_RESET);
        st(8'h00);
        irq(1'b1);
        host_u.wr(4'h3, 8'hff);
        host_u.rd(4'h3, rv);
        chk(rv, 8'h00);
    endtask
    task automatic s_alarm_w();
        alarm_w_time = '{minute: 7'h30, hour: 6'h12, weekday: 3'h3};
        cur_time = alarm_w_time;
        host_u.wr(ADDR_INT_EN, 8'h80);
        pulse('0);
        irq(1'b1);
        pulse('{default: 1'b0, min_tick: 1'b1});
        irq(1'b0);
        st(8'h02);
        host_u.wr(ADDR_STATUS, 8'h03);
        st(8'h02);
        host_u.wr(ADDR_STATUS, 8'h00);
        cyc(3);
        irq(1'b1);
        host_u.rd(ADDR_INT_EN, rv);
        chk(rv, 8'h80);
        cur_time.weekday = 3'h4;
        pulse('{default: 1'b0, min_tick: 1'b1});
        irq(1'b1);
        cur_time.weekday = 3'h3;
        pulse('{default: 1'b0, min_tick: 1'b1});
        irq(1'b0);
        host_u.wr(ADDR_STATUS, 8'h00);
        host_u.wr(ADDR_INT_EN, 8'h00);
        pulse('{default: 1'b0, min_tick: 1'b1});
        irq(1'b1);
    endtask
    task automatic s_periodic();
        host_u.wr(ADDR_INT_EN, 8'h00);
        alarm_d_time = '{minute: 7'h30, hour: 6'h12, weekday: 3'h6};
        host_u.wr(ADDR_INT_EN, 8'h44);
        pulse('{default: 1'b0, min_tick: 1'b1});
        pulse('{default: 1'b0, sec_tick: 1'b1});
        st(8'h05);
        host_u.wr(ADDR_STATUS, 8'h04);
        cyc(3);
        irq(1'b0);
        host_u.wr(ADDR_STATUS, 8'h00);
        cyc(3);
        irq(1'b1);
        for (int m = 4; m < 8; m++) begin
            host_u.wr(ADDR_INT_EN, 8'(m));
            pulse(rtcm_ticks_t'(5'h10 >> (m - 4)));
            irq(1'b0);
            host_u.wr(ADDR_STATUS, 8'h00);
            cyc(3);
            irq(1'b1);
        end
        host_u.wr(ADDR_INT_EN, {5'h00, CT_LOW});
        cyc(3);
        irq(1'b0);
        host_u.wr(ADDR_INT_EN, {5'h00, CT_2HZ});
        ticks.half_sec_level = 1'b1;
        cyc(4);
        rv = 8'(interrupt_out_n);
        ticks.half_sec_level = 1'b0;
        cyc(4);
        chk(rv ^ 8'(interrupt_out_n), 8'h01);
        host_u.wr(ADDR_INT_EN, {5'h00, CT_1HZ});
        ticks.half_sec_level = 1'b1;
        cyc(3);
        irq(1'b0);
        ticks.half_sec_level = 1'b0;
        cyc(3);
        irq(1'b1);
        host_u.wr(ADDR_INT_EN, {5'h00, CT_OFF});
        cyc(3);
        irq(1'b1);
    endtask
    task automatic s_supply();
        chk(8'(host_reset_out_n), 8'h00);
        chk(8'(battery_supply_switch), 8'h01);
        main_supply_above = 1'b1;
        rel_wait();
        chk(8'(main_supply_switch), 8'h01);
        chk(8'(battery_supply_switch), 8'h00);
        osc_running = 1'b0;
        main_supply_above = 1'b0;
        cyc(3);
        chk(8'(host_reset_out_n), 8'h00);
        chk(8'(main_supply_switch), 8'h00);
        main_supply_above = 1'b1;
        cyc(3 * REL);
        chk(8'(host_reset_out_n), 8'h00);
        osc_running = 1'b1;
        rel_wait();
    endtask
    task automatic s_lowsup();
        host_u.wr(ADDR_INT_EN, 8'hff);
        host_u.rd(ADDR_INT_EN, rv);
        chk(rv, 8'hc7);
        host_u.wr(ADDR_STATUS, 8'h80);
        st(8'h80);
        supply_below_high = 1'b1;
        pulse('{default: 1'b0, sec_tick: 1'b1});
        chk(8'(supply_sample_en), 8'h01);
        cyc(20);
        st(8'h80);
        supply_below_low = 1'b1;
        cyc(3);
        st(8'hc0);
        pulse('{default: 1'b0, sec_tick: 1'b1});
        chk(8'(supply_sample_en), 8'h00);
        host_u.wr(ADDR_STATUS, 8'h40);
        st(8'h40);
        supply_below_low = 1'b0;
        host_u.wr(ADDR_STATUS, 8'h00);
        st(8'h00);
        pulse('{default: 1'b0, sec_tick: 1'b1});
        st(8'h40);
        power_up_flag = 1'b1;
        cyc(2);
        st(8'h10);
        power_up_flag = 1'b0;
        host_u.rd(ADDR_INT_EN, rv);
        chk(rv, 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        power_up_flag = 1'b0;
        osc_running = 1'b1;
        main_supply_above = 1'b0;
        supply_below_high = 1'b0;
        supply_below_low = 1'b0;
        cur_time = '0;
        alarm_w_time = '0;
        alarm_d_time = '0;
        ticks = '0;
        repeat (5) @(posedge sys_clk);
        cyc(1);
        rst = 1'b0;
        s_reset();
        s_alarm_w();
        s_periodic();
        s_supply();
        s_lowsup();
        stop_test();
    end
endmodule
`default_nettype wire
